// File: design/hfp_params.svh
/*
  Constants of the host register port: offsets, reset values, field positions.
  Assumes inclusion by the package and by every design file that needs a number.
*/
// Notes on behaviour
// RULE_01 - Reading the status pop port returns the oldest entry and removes it.
// RULE_02 - Reading the status peek port returns the oldest entry, leaving the queue.
// RULE_03 - Transmit data window is write only; each write pushes one word. In 16-bit mode the code pushes one word per pair of halfword writes.
// RULE_04 - In 32-bit mode the window is eight doubleword aliases, 20h to 3Ch.
// RULE_05 - In 16-bit mode the same window holds sixteen halfword aliases.
// RULE_06 - Every alias of the window pushes into the one same data queue.
// RULE_07 - Control and status registers decode directly at offsets 50h to B4h.
// RULE_08 - 60h, 94h, B8h-FCh are reserved; host never writes, reads undefined.
// RULE_09 - Byte order test register is read only and returns 87654321h.
// RULE_10 - Identity bits 31-16 are a read-only design code.
// RULE_11 - Identity bits 15-0 are a read-only silicon revision.
// RULE_12 - Timer configuration and timer count both reset to 0000FFFFh.
// RULE_13 - MAC registers are reached via command at A4h and data at A8h.
// RULE_14 - Configuration memory is reached via command at B0h and data at B4h.
// RULE_15 - Reads of write-only locations, the data window included, return zero.
// RULE_16 - Writes to read-only registers are ignored.
// RULE_17 - Any reset loads every configuration register with its default.
// RULE_18 - Offsets are byte addresses of aligned 32-bit registers, full-width access.
`ifndef HFP_PARAMS_SVH
`define HFP_PARAMS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define HFP_OFS_STS_POP 8'h48
`define HFP_OFS_STS_PEEK 8'h4c
`define HFP_OFS_TXD_LO 8'h20
`define HFP_OFS_TXD_HI 8'h3c
`define HFP_OFS_ID 8'h50
`define HFP_OFS_IRQ_CFG 8'h54
`define HFP_OFS_INTERRUPT_STATUS 8'h58
`define HFP_OFS_INT_EN 8'h5c
`define HFP_OFS_BYTE_TEST 8'h64
`define HFP_OFS_FIFO_INT 8'h68
`define HFP_OFS_RX_CFG 8'h6c
`define HFP_OFS_TX_CFG 8'h70
`define HFP_OFS_HARDWARE_CONFIG 8'h74
`define HFP_OFS_RX_DP 8'h78
`define HFP_OFS_RX_INF 8'h7c
`define HFP_OFS_TX_INF 8'h80
`define HFP_OFS_PMT 8'h84
`define HFP_OFS_GPIO 8'h88
`define HFP_OFS_TMR_CFG 8'h8c
`define HFP_OFS_TMR_CNT 8'h90
`define HFP_OFS_SWAP 8'h98
`define HFP_OFS_FREE_RUN 8'h9c
`define HFP_OFS_RX_DROP 8'ha0
`define HFP_OFS_MAC_CMD 8'ha4
`define HFP_OFS_MAC_DATA 8'ha8
`define HFP_OFS_AFC 8'hac
`define HFP_OFS_MEM_CMD 8'hb0
`define HFP_OFS_MEM_DATA 8'hb4

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define HFP_RST_ZERO 32'h0000_0000
`define HFP_RST_FIFO_INT 32'h4800_0000
`define HFP_RST_HARDWARE_CONFIG 32'h0005_0000
`define HFP_RST_TX_INF 32'h0000_1200
`define HFP_RST_TIMER 32'h0000_ffff
`define HFP_BYTE_PATTERN 32'h8765_4321
// Arbitrary neutral identity values
`define HFP_CHIP_CODE 16'h0a5c
`define HFP_CHIP_REV 16'h0003

// ----------------------------------------
// Fields and sizes
// ----------------------------------------
`define HFP_ID_CODE_LSB 16
`define HFP_TXINF_FREE_LSB 0
`define HFP_TXINF_USED_LSB 16
`define HFP_FIFO_AW 4
`define HFP_FIFO_DEPTH 16

`endif

// File: design/hfp_pkg.sv
/*
  Types of the host register port.
  Assumes the constants header is on the include path.
*/
`include "hfp_params.svh"
package hfp_pkg;

  // ----------------------------------------
  // Host bus request
  // ----------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } hfp_req_t;

  typedef enum logic [2:0] {
    HFP_IDLE = 3'b001,
    HFP_READ = 3'b010,
    HFP_HOLD = 3'b100
  } hfp_state_t;

endpackage

// File: design/hfp_mem.sv
/*
  Small two-port memory for a queue: one write port, one registered read port.
  Assumes a single clock; read data follows the address one edge later.
*/
`timescale 1ns/100ps
`include "hfp_params.svh"
module hfp_mem (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic we,
  input wire logic [`HFP_FIFO_AW-1:0] waddr,
  input wire logic [31:0] wdata,
  // Read side
  input wire logic [`HFP_FIFO_AW-1:0] raddr,
  output logic [31:0] rdata
);
  logic [31:0] mem [`HFP_FIFO_DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // hfp_mem

// File: design/hfp_queue.sv
/*
  Synchronous first-in first-out queue of 32-bit words built on hfp_mem.
  Head word appears on head_data at the edge it becomes the head, but no earlier than one edge after it is written.
  Assumes callers never push when full nor pop when empty (both are ignored).
*/
`timescale 1ns/100ps
`include "hfp_params.svh"
module hfp_queue (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic push,
  input wire logic [31:0] push_data,
  // Drain side
  input wire logic pop,
  output logic [31:0] head_data,
  output logic [`HFP_FIFO_AW:0] level
);
  logic [`HFP_FIFO_AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [`HFP_FIFO_AW:0] lvl_reg, lvl_next;
  logic do_push, do_pop;

  always_comb begin
    do_push = push && (lvl_reg != (`HFP_FIFO_AW+1)'(`HFP_FIFO_DEPTH));
    do_pop = pop && (lvl_reg != '0);
    wp_next = do_push ? wp_reg + 1'b1 : wp_reg;
    rp_next = do_pop ? rp_reg + 1'b1 : rp_reg;
    lvl_next = lvl_reg + {{`HFP_FIFO_AW{1'b0}}, do_push} - {{`HFP_FIFO_AW{1'b0}}, do_pop};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      lvl_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      lvl_reg <= lvl_next;
    end
  end

  assign level = lvl_reg;

  // Read address uses the next pointer so the head is fresh right after a pop
  hfp_mem u_mem (
    .clk(clk),
    .we(do_push),
    .waddr(wp_reg),
    .wdata(push_data),
    .raddr(rp_next),
    .rdata(head_data)
  );
endmodule // hfp_queue

// File: design/hfp_regs.sv
/*
  Host register port: direct decode of the control and status map, the
  transmit status pop and peek ports, and the aliased transmit data window.
  Assumes an SRAM-like host: one-cycle RD or WR strobe with stable address,
  read data valid two edges after the read strobe (RDATA_VALID marks it).
  Transmit status entries come from the transmit engine on STS_PUSH.
*/
`timescale 1ns/100ps
`include "hfp_params.svh"
module hfp_regs (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Bus width strap: high selects 16-bit mode
  input wire logic BUS16,
  // Host bus
  input wire logic RD,
  input wire logic WR,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  output logic [31:0] RDATA,
  output logic RDATA_VALID,
  // Transmit data queue side
  output logic TXD_PUSH,
  output logic [31:0] TXD_DATA,
  // Transmit status from engine
  input wire logic STS_PUSH,
  input wire logic [31:0] STS_DATA,
  // Indirect access strobes
  output logic MAC_CMD_WR,
  output logic MEM_CMD_WR,
  output logic [31:0] MAC_CMD,
  output logic [31:0] MEM_CMD
);
  hfp_pkg::hfp_req_t req;
  hfp_pkg::hfp_state_t st_reg, st_next;
  logic [7:0] raddr_reg, raddr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic rv_reg, rv_next;
  logic txd_push_reg, txd_push_next;
  logic [31:0] txd_data_reg, txd_data_next;
  logic mac_wr_reg, mac_wr_next, mem_wr_reg, mem_wr_next;
  logic [31:0] sts_head;
  logic [`HFP_FIFO_AW:0] sts_level;
  logic sts_pop;
  logic in_window;
  logic [15:0] half_reg, half_next;
  logic half_have_reg, half_have_next;

  // ----------------------------------------
  // Register storage: writable registers, the timer count and the free-running counter
  // ----------------------------------------
  logic [31:0] irq_cfg_reg, irq_cfg_next;
  logic [31:0] interrupt_status_reg, interrupt_status_next;
  logic [31:0] int_en_reg, int_en_next;
  logic [31:0] fifo_int_reg, fifo_int_next;
  logic [31:0] rx_cfg_reg, rx_cfg_next;
  logic [31:0] tx_cfg_reg, tx_cfg_next;
  logic [31:0] hardware_config_reg, hardware_config_next;
  logic [31:0] rx_dp_reg, rx_dp_next;
  logic [31:0] pmt_reg, pmt_next;
  logic [31:0] gpio_reg, gpio_next;
  logic [31:0] tmr_cfg_reg, tmr_cfg_next;
  logic [31:0] tmr_cnt_reg, tmr_cnt_next;
  logic [31:0] swap_reg, swap_next;
  logic [31:0] free_reg, free_next;
  logic [31:0] mac_cmd_reg, mac_cmd_next;
  logic [31:0] mac_data_reg, mac_data_next;
  logic [31:0] afc_reg, afc_next;
  logic [31:0] mem_cmd_reg, mem_cmd_next;
  logic [31:0] mem_data_reg, mem_data_next;

  assign req = '{rd: RD, wr: WR, addr: ADDR, wdata: WDATA};

  // Whole window is one queue; low address bits are ignored on purpose
  assign in_window = (req.addr >= `HFP_OFS_TXD_LO) && (req.addr <= (`HFP_OFS_TXD_HI + 8'h03)); // [RULE_04] [RULE_06]
  // Pop in the answer cycle: the head is muxed out first, then the queue advances
  assign sts_pop = (st_reg == hfp_pkg::HFP_READ) && (raddr_reg == `HFP_OFS_STS_POP); // [RULE_01]

  // ----------------------------------------
  // Transmit status queue
  // ----------------------------------------
  hfp_queue u_sts (
    .clk(CLK),
    .rst_n(RST_N),
    .push(STS_PUSH),
    .push_data(STS_DATA),
    .pop(sts_pop),
    .head_data(sts_head),
    .level(sts_level)
  );

  // ----------------------------------------
  // Bus sequencing and data window
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    raddr_next = raddr_reg;
    rv_next = 1'b0;
    txd_push_next = 1'b0;
    txd_data_next = txd_data_reg;
    half_next = half_reg;
    half_have_next = half_have_reg;
    unique case (st_reg)
      hfp_pkg::HFP_IDLE: begin
        if (req.rd) begin
          raddr_next = req.addr;
          st_next = hfp_pkg::HFP_READ;
        end else if (req.wr && in_window) begin
          if (!BUS16) begin
            txd_push_next = 1'b1; // [RULE_03] [RULE_06]
            txd_data_next = req.wdata;
          end else if (!half_have_reg) begin
            half_next = req.wdata[15:0]; // [RULE_05]
            half_have_next = 1'b1;
          end else begin
            txd_push_next = 1'b1; // [RULE_05]
            txd_data_next = {req.wdata[15:0], half_reg};
            half_have_next = 1'b0;
          end
        end
      end
      hfp_pkg::HFP_READ: begin
        rv_next = 1'b1;
        st_next = hfp_pkg::HFP_HOLD;
      end
      hfp_pkg::HFP_HOLD: begin
        st_next = hfp_pkg::HFP_IDLE;
      end
      default: begin
        st_next = hfp_pkg::HFP_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    rdata_next = rdata_reg;
    if (st_reg == hfp_pkg::HFP_READ) begin
      unique case (raddr_reg)
        `HFP_OFS_STS_POP, `HFP_OFS_STS_PEEK: rdata_next = sts_head; // [RULE_01] [RULE_02]
        `HFP_OFS_ID: rdata_next = {`HFP_CHIP_CODE, `HFP_CHIP_REV}; // [RULE_10] [RULE_11]
        `HFP_OFS_IRQ_CFG: rdata_next = irq_cfg_reg; // [RULE_07]
        `HFP_OFS_INTERRUPT_STATUS: rdata_next = interrupt_status_reg;
        `HFP_OFS_INT_EN: rdata_next = int_en_reg;
        `HFP_OFS_BYTE_TEST: rdata_next = `HFP_BYTE_PATTERN; // [RULE_09]
        `HFP_OFS_FIFO_INT: rdata_next = fifo_int_reg;
        `HFP_OFS_RX_CFG: rdata_next = rx_cfg_reg;
        `HFP_OFS_TX_CFG: rdata_next = tx_cfg_reg;
        `HFP_OFS_HARDWARE_CONFIG: rdata_next = hardware_config_reg;
        `HFP_OFS_RX_DP: rdata_next = rx_dp_reg;
        `HFP_OFS_RX_INF: rdata_next = `HFP_RST_ZERO;
        `HFP_OFS_TX_INF: rdata_next = `HFP_RST_TX_INF | (32'(sts_level) << `HFP_TXINF_USED_LSB);
        `HFP_OFS_PMT: rdata_next = pmt_reg;
        `HFP_OFS_GPIO: rdata_next = gpio_reg;
        `HFP_OFS_TMR_CFG: rdata_next = tmr_cfg_reg;
        `HFP_OFS_TMR_CNT: rdata_next = tmr_cnt_reg;
        `HFP_OFS_SWAP: rdata_next = swap_reg;
        `HFP_OFS_FREE_RUN: rdata_next = free_reg;
        `HFP_OFS_RX_DROP: rdata_next = `HFP_RST_ZERO;
        `HFP_OFS_MAC_CMD: rdata_next = mac_cmd_reg; // [RULE_13]
        `HFP_OFS_MAC_DATA: rdata_next = mac_data_reg; // [RULE_13]
        `HFP_OFS_AFC: rdata_next = afc_reg;
        `HFP_OFS_MEM_CMD: rdata_next = mem_cmd_reg; // [RULE_14]
        `HFP_OFS_MEM_DATA: rdata_next = mem_data_reg; // [RULE_14]
        // Data window, reserved and unmapped reads give zero
        default: rdata_next = `HFP_RST_ZERO; // [RULE_15] [RULE_08]
      endcase
    end
  end

  // ----------------------------------------
  // Register writes; read-only offsets fall through untouched
  // ----------------------------------------
  always_comb begin
    irq_cfg_next = irq_cfg_reg;
    interrupt_status_next = interrupt_status_reg;
    int_en_next = int_en_reg;
    fifo_int_next = fifo_int_reg;
    rx_cfg_next = rx_cfg_reg;
    tx_cfg_next = tx_cfg_reg;
    hardware_config_next = hardware_config_reg;
    rx_dp_next = rx_dp_reg;
    pmt_next = pmt_reg;
    gpio_next = gpio_reg;
    tmr_cfg_next = tmr_cfg_reg;
    swap_next = swap_reg;
    mac_cmd_next = mac_cmd_reg;
    mac_data_next = mac_data_reg;
    afc_next = afc_reg;
    mem_cmd_next = mem_cmd_reg;
    mem_data_next = mem_data_reg;
    mac_wr_next = 1'b0;
    mem_wr_next = 1'b0;
    free_next = free_reg + 32'h0000_0001;
    // Count runs down every cycle and reloads with its period from the timer configuration at zero; a timer configuration write also loads it
    tmr_cnt_next = (tmr_cnt_reg == '0) ? tmr_cfg_reg : tmr_cnt_reg - 32'h0000_0001;
    if (st_reg == hfp_pkg::HFP_IDLE && req.wr) begin
      unique case (req.addr) // [RULE_07] [RULE_16] [RULE_18]
        `HFP_OFS_IRQ_CFG: irq_cfg_next = req.wdata;
        `HFP_OFS_INTERRUPT_STATUS: interrupt_status_next = interrupt_status_reg & ~req.wdata;
        `HFP_OFS_INT_EN: int_en_next = req.wdata;
        `HFP_OFS_FIFO_INT: fifo_int_next = req.wdata;
        `HFP_OFS_RX_CFG: rx_cfg_next = req.wdata;
        `HFP_OFS_TX_CFG: tx_cfg_next = req.wdata;
        `HFP_OFS_HARDWARE_CONFIG: hardware_config_next = req.wdata;
        `HFP_OFS_RX_DP: rx_dp_next = req.wdata;
        `HFP_OFS_PMT: pmt_next = req.wdata;
        `HFP_OFS_GPIO: gpio_next = req.wdata;
        `HFP_OFS_TMR_CFG: begin
          tmr_cfg_next = req.wdata;
          tmr_cnt_next = req.wdata;
        end
        `HFP_OFS_SWAP: swap_next = req.wdata;
        `HFP_OFS_MAC_CMD: begin
          mac_cmd_next = req.wdata; // [RULE_13]
          mac_wr_next = 1'b1;
        end
        `HFP_OFS_MAC_DATA: mac_data_next = req.wdata;
        `HFP_OFS_AFC: afc_next = req.wdata;
        `HFP_OFS_MEM_CMD: begin
          mem_cmd_next = req.wdata; // [RULE_14]
          mem_wr_next = 1'b1;
        end
        `HFP_OFS_MEM_DATA: mem_data_next = req.wdata;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_reg <= hfp_pkg::HFP_IDLE;
      raddr_reg <= '0;
      rdata_reg <= `HFP_RST_ZERO;
      rv_reg <= 1'b0;
      txd_push_reg <= 1'b0;
      txd_data_reg <= `HFP_RST_ZERO;
      half_reg <= '0;
      half_have_reg <= 1'b0;
      mac_wr_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      irq_cfg_reg <= `HFP_RST_ZERO; // [RULE_17]
      interrupt_status_reg <= `HFP_RST_ZERO;
      int_en_reg <= `HFP_RST_ZERO;
      fifo_int_reg <= `HFP_RST_FIFO_INT;
      rx_cfg_reg <= `HFP_RST_ZERO;
      tx_cfg_reg <= `HFP_RST_ZERO;
      hardware_config_reg <= `HFP_RST_HARDWARE_CONFIG;
      rx_dp_reg <= `HFP_RST_ZERO;
      pmt_reg <= `HFP_RST_ZERO;
      gpio_reg <= `HFP_RST_ZERO;
      tmr_cfg_reg <= `HFP_RST_TIMER; // [RULE_12]
      tmr_cnt_reg <= `HFP_RST_TIMER; // [RULE_12]
      swap_reg <= `HFP_RST_ZERO;
      free_reg <= `HFP_RST_ZERO;
      mac_cmd_reg <= `HFP_RST_ZERO;
      mac_data_reg <= `HFP_RST_ZERO;
      afc_reg <= `HFP_RST_ZERO;
      mem_cmd_reg <= `HFP_RST_ZERO;
      mem_data_reg <= `HFP_RST_ZERO;
    end else begin
      st_reg <= st_next;
      raddr_reg <= raddr_next;
      rdata_reg <= rdata_next;
      rv_reg <= rv_next;
      txd_push_reg <= txd_push_next;
      txd_data_reg <= txd_data_next;
      half_reg <= half_next;
      half_have_reg <= half_have_next;
      mac_wr_reg <= mac_wr_next;
      mem_wr_reg <= mem_wr_next;
      irq_cfg_reg <= irq_cfg_next;
      interrupt_status_reg <= interrupt_status_next;
      int_en_reg <= int_en_next;
      fifo_int_reg <= fifo_int_next;
      rx_cfg_reg <= rx_cfg_next;
      tx_cfg_reg <= tx_cfg_next;
      hardware_config_reg <= hardware_config_next;
      rx_dp_reg <= rx_dp_next;
      pmt_reg <= pmt_next;
      gpio_reg <= gpio_next;
      tmr_cfg_reg <= tmr_cfg_next;
      tmr_cnt_reg <= tmr_cnt_next;
      swap_reg <= swap_next;
      free_reg <= free_next;
      mac_cmd_reg <= mac_cmd_next;
      mac_data_reg <= mac_data_next;
      afc_reg <= afc_next;
      mem_cmd_reg <= mem_cmd_next;
      mem_data_reg <= mem_data_next;
    end
  end

  assign RDATA = rdata_reg;
  assign RDATA_VALID = rv_reg;
  assign TXD_PUSH = txd_push_reg;
  assign TXD_DATA = txd_data_reg;
  assign MAC_CMD_WR = mac_wr_reg;
  assign MEM_CMD_WR = mem_wr_reg;
  assign MAC_CMD = mac_cmd_reg;
  assign MEM_CMD = mem_cmd_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_byte_pattern: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_09]
    (st_reg == hfp_pkg::HFP_IDLE && RD && ADDR == `HFP_OFS_BYTE_TEST)
      |-> ##2 (RDATA_VALID && RDATA == `HFP_BYTE_PATTERN))
    else $error("byte order pattern wrong");
  chk_id_value: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_10]
    (st_reg == hfp_pkg::HFP_IDLE && RD && ADDR == `HFP_OFS_ID)
      |-> ##2 (RDATA[31:16] == `HFP_CHIP_CODE))
    else $error("identity code wrong");
  chk_rev_value: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_11]
    (st_reg == hfp_pkg::HFP_IDLE && RD && ADDR == `HFP_OFS_ID)
      |-> ##2 (RDATA[15:0] == `HFP_CHIP_REV))
    else $error("revision wrong");
  chk_window_push: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_04]
    (st_reg == hfp_pkg::HFP_IDLE && WR && !RD && in_window && !BUS16)
      |=> (TXD_PUSH && TXD_DATA == $past(WDATA)))
    else $error("window write did not push");
  chk_half_pair: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_05]
    (st_reg == hfp_pkg::HFP_IDLE && WR && !RD && in_window && BUS16 && !half_have_reg)
      |=> !TXD_PUSH)
    else $error("first halfword pushed early");
  chk_window_reads_zero: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_15]
    (st_reg == hfp_pkg::HFP_IDLE && RD && in_window) |-> ##2 (RDATA == '0))
    else $error("data window read not zero");
  chk_peek_keeps: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_02]
    (st_reg == hfp_pkg::HFP_IDLE && RD && ADDR == `HFP_OFS_STS_PEEK && !STS_PUSH)
      |=> (sts_level == $past(sts_level)))
    else $error("peek changed the level");
  chk_pop_drops: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_01]
    (sts_pop && sts_level != '0 && !STS_PUSH) |=> (sts_level == $past(sts_level) - 1'b1))
    else $error("pop did not remove entry");
  chk_timer_reset: assert property (@(posedge CLK) // [RULE_12]
    $rose(RST_N) |-> (tmr_cfg_reg == `HFP_RST_TIMER))
    else $error("timer config reset wrong");
  chk_ro_ignored: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_16]
    (st_reg == hfp_pkg::HFP_IDLE && WR && !RD && ADDR == `HFP_OFS_BYTE_TEST)
      |=> (!TXD_PUSH && !MAC_CMD_WR && !MEM_CMD_WR))
    else $error("read-only write had an effect");
endmodule // hfp_regs

// File: test/hfp_engine_model.sv
/*
  Transmit engine model beside the register port: feeds status entries and
  collects every word pushed into the transmit data queue.
  Assumes one clock shared with the port.
*/
`timescale 1ns/100ps
module hfp_engine_model (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Data queue side
  input wire logic TXD_PUSH,
  input wire logic [31:0] TXD_DATA,
  // Status side
  output logic STS_PUSH,
  output logic [31:0] STS_DATA
);
  logic [31:0] txd_q [$];

  initial begin
    STS_PUSH = 1'b0;
    STS_DATA = 32'h0000_0000;
  end

  always @(posedge CLK) begin
    if (RST_N === 1'b1 && TXD_PUSH === 1'b1) begin
      txd_q.push_back(TXD_DATA);
    end
  end

  task automatic push_status(input logic [31:0] d);
    @(posedge CLK);
    STS_PUSH <= 1'b1;
    STS_DATA <= d;
    @(posedge CLK);
    STS_PUSH <= 1'b0;
    // Data is not held after the pulse, so a late sample cannot match
    STS_DATA <= ~d;
  endtask
endmodule // hfp_engine_model

// File: test/hfp_regs_tb.sv
/*
  Self-checking bench of the host register port.
  Assumes the design files and the engine model are compiled first.
*/
`timescale 1ns/100ps
`include "hfp_params.svh"
module hfp_regs_tb;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic BUS16 = 1'b0;
  logic RD = 1'b0;
  logic WR = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0000_0000;
  logic [31:0] RDATA, TXD_DATA, STS_DATA, MAC_CMD, MEM_CMD, rv;
  logic RDATA_VALID, TXD_PUSH, STS_PUSH, MAC_CMD_WR, MEM_CMD_WR, p_mac, p_mem;
  int errors = 0;
  int n_tests = 0;

  always #50 CLK = ~CLK;

  hfp_regs hfp_regs_i (.CLK(CLK), .RST_N(RST_N), .BUS16(BUS16), .RD(RD), .WR(WR), .ADDR(ADDR),
    .WDATA(WDATA), .RDATA(RDATA), .RDATA_VALID(RDATA_VALID), .TXD_PUSH(TXD_PUSH), .TXD_DATA(TXD_DATA),
    .STS_PUSH(STS_PUSH), .STS_DATA(STS_DATA), .MAC_CMD_WR(MAC_CMD_WR), .MEM_CMD_WR(MEM_CMD_WR),
    .MAC_CMD(MAC_CMD), .MEM_CMD(MEM_CMD));
  hfp_engine_model hfp_engine_model_i (.CLK(CLK), .RST_N(RST_N), .TXD_PUSH(TXD_PUSH),
    .TXD_DATA(TXD_DATA), .STS_PUSH(STS_PUSH), .STS_DATA(STS_DATA));

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic close_out;
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reads return after the answer, which keeps reads three cycles apart
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int i;
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(posedge CLK);
      #1;
      if (RDATA_VALID === 1'b1) break;
    end
    if (i == 4) begin
      errors++;
      $display("Error at %0t: no read answer", $time);
      close_out();
    end
    d = RDATA;
  endtask

  // Full-width write data; the 16-bit window test also uses it at halfword offsets such as 22h
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
    // Command strobes stand only in the cycle after the taken edge
    #1;
    p_mac = MAC_CMD_WR;
    p_mem = MEM_CMD_WR;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_map;
    logic [7:0] ofs [0:9] = '{8'h50, 8'h54, 8'h64, 8'h68, 8'h74, 8'h80, 8'h8c, 8'h98, 8'ha4, 8'hb4};
    logic [31:0] val [0:9] = '{{`HFP_CHIP_CODE, `HFP_CHIP_REV}, 32'h0, 32'h8765_4321, 32'h4800_0000,
      32'h0005_0000, 32'h0000_1200, 32'h0000_ffff, 32'h0, 32'h0, 32'h0};
    for (int k = 0; k < 10; k++) begin
      rd(ofs[k], rv);
      cmp(rv, val[k]);
    end
  endtask

  task automatic t_read_only;
    logic [7:0] rsv [0:3] = '{8'h60, 8'h94, 8'hb8, 8'hfc};
    wr(8'h50, 32'hffff_ffff);
    wr(8'h64, 32'h0000_0000);
    rd(8'h50, rv);
    cmp(rv, {`HFP_CHIP_CODE, `HFP_CHIP_REV});
    rd(8'h64, rv);
    cmp(rv, 32'h8765_4321);
    // Reserved places are only read, never written
    for (int k = 0; k < 4; k++) begin
      rd(rsv[k], rv);
      cmp(rv, 32'h0000_0000);
    end
  endtask

  task automatic t_window(input logic wide16);
    int n;
    n = wide16 ? 16 : 8;
    hfp_engine_model_i.txd_q.delete();
    @(posedge CLK);
    BUS16 <= wide16;
    for (int k = 0; k < n; k++) begin
      wr(8'h20 + 8'(wide16 ? 2 * k : 4 * k), {16'hffff - 16'(k), 16'h0b00 + 16'(k)});
    end
    rd(8'h20, rv);
    cmp(rv, 32'h0000_0000);
    cmp(32'(hfp_engine_model_i.txd_q.size()), 32'h8);
    for (int j = 0; j < 8 && j < hfp_engine_model_i.txd_q.size(); j++) begin
      if (wide16) cmp(hfp_engine_model_i.txd_q[j], {16'h0b01 + 16'(2 * j), 16'h0b00 + 16'(2 * j)});
      else cmp(hfp_engine_model_i.txd_q[j], {16'hffff - 16'(j), 16'h0b00 + 16'(j)});
    end
    @(posedge CLK);
    BUS16 <= 1'b0;
  endtask

  task automatic t_status;
    hfp_engine_model_i.push_status(32'hc0c0_0001);
    hfp_engine_model_i.push_status(32'hc0c0_0002);
    hfp_engine_model_i.push_status(32'hc0c0_0003);
    rd(8'h80, rv);
    cmp(rv, 32'h0003_1200);
    rd(`HFP_OFS_STS_PEEK, rv);
    cmp(rv, 32'hc0c0_0001);
    rd(`HFP_OFS_STS_PEEK, rv);
    cmp(rv, 32'hc0c0_0001);
    rd(`HFP_OFS_STS_POP, rv);
    cmp(rv, 32'hc0c0_0001);
    rd(`HFP_OFS_STS_PEEK, rv);
    cmp(rv, 32'hc0c0_0002);
    rd(8'h80, rv);
    cmp(rv, 32'h0002_1200);
  endtask

  task automatic t_indirect;
    wr(8'ha4, 32'h8000_0a05);
    cmp({30'h0, p_mac, p_mem}, 32'h2);
    cmp(MAC_CMD, 32'h8000_0a05);
    wr(8'hb0, 32'h9000_0077);
    cmp({30'h0, p_mac, p_mem}, 32'h1);
    cmp(MEM_CMD, 32'h9000_0077);
    wr(8'ha8, 32'h1357_9bdf);
    wr(8'hb4, 32'h0000_00a5);
    rd(8'ha8, rv);
    cmp(rv, 32'h1357_9bdf);
    rd(8'hb4, rv);
    cmp(rv, 32'h0000_00a5);
  endtask

  task automatic t_reset_again;
    wr(8'h6c, 32'h0000_3300);
    wr(8'h8c, 32'h0000_0040);
    rd(8'h6c, rv);
    cmp(rv, 32'h0000_3300);
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    rd(8'h6c, rv);
    cmp(rv, 32'h0000_0000);
    rd(8'h8c, rv);
    cmp(rv, 32'h0000_ffff);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset_map();
    t_read_only();
    t_window(1'b0);
    t_window(1'b1);
    t_status();
    t_indirect();
    t_reset_again();
    close_out();
  end
endmodule // hfp_regs_tb
